// [core/umh_modem.sv]
// Purpose: Modem control outputs and modem status inputs for two serial ports.
// Assumes: One 50 MHz clock; asynchronous active-low reset; APB slave, zero wait.
// Notes: Modem inputs are asynchronous and pass two flip-flops first.
//
// Decided for this implementation: the APB slave port and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none

module umh_modem
	import umh_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic send_request_n_port1,
	output logic send_request_n_port2,
	input wire logic send_request_n_port2_in,
	output logic send_request_n_port2_oe,
	output logic terminal_ready_n,
	output logic terminal_ready_n_port2,
	input wire logic clear_to_send_n_port1,
	input wire logic clear_to_send_n_port2,
	input wire logic set_ready_n_port1,
	input wire logic set_ready_n_port2,
	input wire logic carrier_detect_n_port1,
	input wire logic carrier_detect_n_port2,
	input wire logic ring_indicator_n,
	input wire logic ring_indicator_n_port2,
	output logic irq_port1,
	output logic irq_port2,
	output logic [15:0] config_base_strap
);

	umh_state_t state;
	umh_state_t next_state;
	logic access;
	logic wr;
	logic rd;
	logic [31:0] rdata;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Builds the status byte: levels inverted from the pins, change bits below.
	function automatic logic [7:0] status_byte(input umh_port_t p);
		logic [3:0] lv;
		lv = ~p.last;
		status_byte = {lv[3], lv[2], lv[1], lv[0], p.delta};
	endfunction

	// Advances one port: pin sampling, change bits, writes and read clears.
	function automatic umh_port_t port_step(input umh_port_t p, input logic [3:0] pins, input logic wr_mcr,
		input logic wr_ier, input logic rd_msr, input logic [7:0] wdata);
		umh_port_t n;
		logic [3:0] rise;
		logic [3:0] drop;
		n = p;
		n.sync1 = pins;
		n.sync2 = p.sync1;
		n.last = p.sync2;
		// Pin low-to-high; the status bit order is cts, dsr, ri, dcd.
		rise = p.sync2 & ~p.last;
		// Pin high-to-low; it sets no status bit but is still a change of state.
		drop = ~p.sync2 & p.last;
		if (rd_msr) begin
			n.delta = 4'h0;
			n.fall = 4'h0;
		end
		n.delta = n.delta | rise;
		// A falling pin is kept pending so that any change can raise the interrupt.
		n.fall = n.fall | drop;
		if (wr_mcr) begin
			n.modem_control_reg = wdata;
		end
		if (wr_ier) begin
			n.ier = wdata;
		end
		port_step = n;
	endfunction

	// Drives the port interrupt from pending changes under enable bit 3.
	function automatic logic port_irq(input umh_port_t p);
		port_irq = p.ier[UMH_IER_MODEM_BIT] & ((|p.delta) | (|p.fall));
	endfunction

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------

	// The slave holds pready high with no wait states; read data is registered at the end of the access cycle.
	assign access = psel & penable;
	assign wr = access & pwrite;
	assign rd = access & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = state.prdata;

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		case (paddr)
			UMH_MCR1_OFF: rdata = {24'h000000, state.p1.modem_control_reg};
			UMH_MSR1_OFF: rdata = {24'h000000, status_byte(state.p1)};
			UMH_IER1_OFF: rdata = {24'h000000, state.p1.ier};
			UMH_MCR2_OFF: rdata = {24'h000000, state.p2.modem_control_reg};
			UMH_MSR2_OFF: rdata = {24'h000000, status_byte(state.p2)};
			UMH_IER2_OFF: rdata = {24'h000000, state.p2.ier};
			UMH_CFG_OFF: rdata = {16'h0000, config_base_strap};
			default: rdata = UMH_BAD_READ;
		endcase
	end

	// ----------------------------------------
	// State update
	// ----------------------------------------

	// Computes the next state of both ports, the strap and the read data.
	always_comb begin
		next_state = state;
		next_state.p1 = port_step(state.p1,
			{carrier_detect_n_port1, ring_indicator_n, set_ready_n_port1, clear_to_send_n_port1},
			wr && paddr == UMH_MCR1_OFF, wr && paddr == UMH_IER1_OFF, rd && paddr == UMH_MSR1_OFF,
			pwdata[7:0]);
		next_state.p2 = port_step(state.p2,
			{carrier_detect_n_port2, ring_indicator_n_port2, set_ready_n_port2, clear_to_send_n_port2},
			wr && paddr == UMH_MCR2_OFF, wr && paddr == UMH_IER2_OFF, rd && paddr == UMH_MSR2_OFF,
			pwdata[7:0]);
		// The pin is not driven during reset, so the first clocked cycle catches the strap.
		if (!state.strap_done) begin
			next_state.strap = send_request_n_port2_in;
			next_state.strap_done = 1'b1;
		end
		if (rd) begin
			next_state.prdata = rdata;
		end
	end

	// Registers the whole state; reset loads constants only.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= '0;
			state.p1.modem_control_reg <= UMH_MCR_RESET;
			state.p2.modem_control_reg <= UMH_MCR_RESET;
			state.p1.ier <= UMH_IER_RESET;
			state.p2.ier <= UMH_IER_RESET;
			state.p1.sync1 <= 4'hF;
			state.p1.sync2 <= 4'hF;
			state.p1.last <= 4'hF;
			state.p2.sync1 <= 4'hF;
			state.p2.sync2 <= 4'hF;
			state.p2.last <= 4'hF;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Pin outputs
	// ----------------------------------------

	// Control outputs are active low and forced high in loopback; the status inputs still follow the pins.
	assign send_request_n_port1 = ~(state.p1.modem_control_reg[UMH_MCR_SR_BIT] & ~state.p1.modem_control_reg[UMH_MCR_LOOP_BIT]);
	assign send_request_n_port2 = ~(state.p2.modem_control_reg[UMH_MCR_SR_BIT] & ~state.p2.modem_control_reg[UMH_MCR_LOOP_BIT]);
	assign send_request_n_port2_oe = state.strap_done;
	assign terminal_ready_n = ~(state.p1.modem_control_reg[UMH_MCR_TR_BIT] & ~state.p1.modem_control_reg[UMH_MCR_LOOP_BIT]);
	assign terminal_ready_n_port2 = ~(state.p2.modem_control_reg[UMH_MCR_TR_BIT] & ~state.p2.modem_control_reg[UMH_MCR_LOOP_BIT]);
	assign irq_port1 = port_irq(state.p1);
	assign irq_port2 = port_irq(state.p2);
	assign config_base_strap = state.strap ? UMH_BASE_STRAP1 : UMH_BASE_STRAP0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------

	// A rising clear-to-send pin reaches the change bit two edges after sampling.
	sequence s_cts_rise;
		$rose(clear_to_send_n_port1) ##1 !state.p1.last[0];
	endsequence

	a_send_req_level: assert property (@(posedge clock) disable iff (!nrst)
		send_request_n_port1 == !(state.p1.modem_control_reg[1] && !state.p1.modem_control_reg[4]))
		else $error("send request pin disagrees with control");
	a_send_req_reset: assert property (@(posedge clock) !nrst |-> send_request_n_port1 && send_request_n_port2)
		else $error("send request not idle in reset");
	a_send_req_loop: assert property (@(posedge clock) disable iff (!nrst)
		state.p2.modem_control_reg[4] |-> send_request_n_port2) else $error("send request active in loopback");
	a_term_ready_set: assert property (@(posedge clock) disable iff (!nrst)
		(wr && paddr == UMH_MCR1_OFF && pwdata[1:0] == 2'b01 && !pwdata[4]) |=> !terminal_ready_n)
		else $error("terminal ready did not follow write");
	a_term_ready_rst: assert property (@(posedge clock) !nrst |-> terminal_ready_n)
		else $error("terminal ready not idle in reset");
	a_term_ready_loop: assert property (@(posedge clock) disable iff (!nrst)
		state.p1.modem_control_reg[4] |-> terminal_ready_n) else $error("terminal ready active in loopback");
	a_cts_delta_set: assert property (@(posedge clock) disable iff (!nrst)
		s_cts_rise ##1 (clear_to_send_n_port1 && !(rd && paddr == UMH_MSR1_OFF)) [*2] |=> state.p1.delta[0])
		else $error("cts change bit not set");
	a_status_clear: assert property (@(posedge clock) disable iff (!nrst)
		(rd && paddr == UMH_MSR1_OFF && state.p1.sync2 == state.p1.last) |=> state.p1.delta == 4'h0)
		else $error("status read did not clear change bits");
	a_irq_gate: assert property (@(posedge clock) disable iff (!nrst)
		irq_port2 |-> state.p2.ier[3] && $past((|next_state.p2.delta) || (|next_state.p2.fall), 1))
		else $error("interrupt without enable or change");
	a_dcd_level: assert property (@(posedge clock) disable iff (!nrst)
		(rd && paddr == UMH_MSR2_OFF) |=> prdata[7] == !$past(state.p2.last[3], 1))
		else $error("carrier level bit wrong");

	// ----------------------------------------
	// Sequences for the other modem input edges
	// ----------------------------------------

	// A rising data-set-ready pin, seen low in the hold flop one edge later.
	sequence s_dsr_rise;
		$rose(set_ready_n_port1) ##1 !state.p1.last[1];
	endsequence

	// A rising carrier-detect pin, seen low in the hold flop one edge later.
	sequence s_dcd_rise;
		$rose(carrier_detect_n_port1) ##1 !state.p1.last[3];
	endsequence

	// A rising ring indicator pin, seen low in the hold flop one edge later.
	sequence s_ri_rise;
		$rose(ring_indicator_n) ##1 !state.p1.last[2];
	endsequence

	// A falling clear-to-send pin, seen high in the hold flop one edge later.
	sequence s_cts_fall;
		$fell(clear_to_send_n_port1) ##1 state.p1.last[0];
	endsequence

	// A falling data-set-ready pin, seen high in the hold flop one edge later.
	sequence s_dsr_fall;
		$fell(set_ready_n_port1) ##1 state.p1.last[1];
	endsequence

	// ----------------------------------------
	// Checks on the control outputs and the strap
	// ----------------------------------------

	// The port-2 send request pin follows its control bit.
	a_send_req2_level: assert property (@(posedge clock) disable iff (!nrst)
		send_request_n_port2 == !(state.p2.modem_control_reg[1] && !state.p2.modem_control_reg[4]))
		else $error("port 2 send request disagrees with control");

	// Loopback keeps the port-1 send request pin idle.
	a_send_req1_loop: assert property (@(posedge clock) disable iff (!nrst)
		state.p1.modem_control_reg[4] |-> send_request_n_port1)
		else $error("port 1 send request active in loopback");

	// A write that sets terminal ready on port 2 drives its pin low next cycle.
	a_term_ready2_set: assert property (@(posedge clock) disable iff (!nrst)
		(wr && paddr == UMH_MCR2_OFF && pwdata[0] && !pwdata[4]) |=> !terminal_ready_n_port2)
		else $error("port 2 terminal ready did not follow write");

	// Reset keeps the port-2 terminal ready pin idle.
	a_term_ready2_rst: assert property (@(posedge clock) !nrst |-> terminal_ready_n_port2)
		else $error("port 2 terminal ready not idle in reset");

	// Loopback keeps the port-2 terminal ready pin idle.
	a_term_ready2_loop: assert property (@(posedge clock) disable iff (!nrst)
		state.p2.modem_control_reg[4] |-> terminal_ready_n_port2)
		else $error("port 2 terminal ready active in loopback");

	// The base chosen by the strap matches the pin level caught after reset.
	a_strap_latch: assert property (@(posedge clock) disable iff (!nrst)
		$rose(send_request_n_port2_oe) |-> config_base_strap == ($past(send_request_n_port2_in, 1) ?
		UMH_BASE_STRAP1 : UMH_BASE_STRAP0))
		else $error("strap base does not match pin");

	// ----------------------------------------
	// Checks on the status levels
	// ----------------------------------------

	// Status bit 4 returns the inverted clear-to-send level.
	a_cts_level: assert property (@(posedge clock) disable iff (!nrst)
		(rd && paddr == UMH_MSR1_OFF) |=> prdata[4] == !$past(state.p1.last[0], 1))
		else $error("clear-to-send level bit wrong");

	// Status bit 5 returns the inverted data-set-ready level.
	a_dsr_level: assert property (@(posedge clock) disable iff (!nrst)
		(rd && paddr == UMH_MSR1_OFF) |=> prdata[5] == !$past(state.p1.last[1], 1))
		else $error("data-set-ready level bit wrong");

	// Status bit 6 returns the inverted ring indicator level.
	a_ri_level: assert property (@(posedge clock) disable iff (!nrst)
		(rd && paddr == UMH_MSR1_OFF) |=> prdata[6] == !$past(state.p1.last[2], 1))
		else $error("ring level bit wrong");

	// ----------------------------------------
	// Checks on change bits and the interrupt
	// ----------------------------------------

	// A rising data-set-ready pin sets change bit 1 unless a read intervenes.
	a_dsr_delta_set: assert property (@(posedge clock) disable iff (!nrst)
		s_dsr_rise ##1 (set_ready_n_port1 && !(rd && paddr == UMH_MSR1_OFF)) [*2] |=> state.p1.delta[1])
		else $error("dsr change bit not set");

	// A rising carrier-detect pin sets change bit 3 unless a read intervenes.
	a_dcd_delta_set: assert property (@(posedge clock) disable iff (!nrst)
		s_dcd_rise ##1 (carrier_detect_n_port1 && !(rd && paddr == UMH_MSR1_OFF)) [*2] |=> state.p1.delta[3])
		else $error("dcd change bit not set");

	// A rising ring indicator pin sets change bit 2 unless a read intervenes.
	a_ri_delta_set: assert property (@(posedge clock) disable iff (!nrst)
		s_ri_rise ##1 (ring_indicator_n && !(rd && paddr == UMH_MSR1_OFF)) [*2] |=> state.p1.delta[2])
		else $error("ri change bit not set");

	// A falling clear-to-send pin raises the enabled interrupt as well.
	a_cts_fall_irq: assert property (@(posedge clock) disable iff (!nrst)
		s_cts_fall ##1 (!clear_to_send_n_port1 && !(rd && paddr == UMH_MSR1_OFF) && state.p1.ier[3] &&
		!(wr && paddr == UMH_IER1_OFF)) [*2] |=> irq_port1)
		else $error("cts fall gave no interrupt");

	// A falling data-set-ready pin raises the enabled interrupt as well.
	a_dsr_fall_irq: assert property (@(posedge clock) disable iff (!nrst)
		s_dsr_fall ##1 (!set_ready_n_port1 && !(rd && paddr == UMH_MSR1_OFF) && state.p1.ier[3] &&
		!(wr && paddr == UMH_IER1_OFF)) [*2] |=> irq_port1)
		else $error("dsr fall gave no interrupt");

	// A rising carrier-detect pin raises the enabled interrupt.
	a_dcd_rise_irq: assert property (@(posedge clock) disable iff (!nrst)
		s_dcd_rise ##1 (carrier_detect_n_port1 && !(rd && paddr == UMH_MSR1_OFF) && state.p1.ier[3] &&
		!(wr && paddr == UMH_IER1_OFF)) [*2] |=> irq_port1)
		else $error("dcd rise gave no interrupt");

	// A rising ring indicator pin raises the enabled interrupt.
	a_ri_rise_irq: assert property (@(posedge clock) disable iff (!nrst)
		s_ri_rise ##1 (ring_indicator_n && !(rd && paddr == UMH_MSR1_OFF) && state.p1.ier[3] &&
		!(wr && paddr == UMH_IER1_OFF)) [*2] |=> irq_port1)
		else $error("ri rise gave no interrupt");

	// With the enable bit clear no change reaches the port-1 interrupt.
	a_irq_enable_off: assert property (@(posedge clock) disable iff (!nrst)
		!state.p1.ier[3] |-> !irq_port1)
		else $error("interrupt while disabled");

	// A port-2 status read with no new edge leaves no change pending.
	a_status_clear2: assert property (@(posedge clock) disable iff (!nrst)
		(rd && paddr == UMH_MSR2_OFF && state.p2.sync2 == state.p2.last) |=> state.p2.delta == 4'h0)
		else $error("port 2 status read did not clear change bits");

endmodule

`default_nettype wire

// [core/umh_pkg.sv]
// Purpose: Constants and types for the modem handshake block of two serial ports.
// Assumes: APB with 32-bit data, one word per register.
// Notes: Register offsets are byte addresses.

package umh_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] UMH_MCR1_OFF = 8'h00;
	localparam logic [7:0] UMH_MSR1_OFF = 8'h04;
	localparam logic [7:0] UMH_IER1_OFF = 8'h08;
	localparam logic [7:0] UMH_MCR2_OFF = 8'h10;
	localparam logic [7:0] UMH_MSR2_OFF = 8'h14;
	localparam logic [7:0] UMH_IER2_OFF = 8'h18;
	localparam logic [7:0] UMH_CFG_OFF = 8'h20;

	// ----------------------------------------
	// Field positions and values
	// ----------------------------------------
	localparam int UMH_MCR_TR_BIT = 0;
	localparam int UMH_MCR_SR_BIT = 1;
	localparam int UMH_MCR_LOOP_BIT = 4;
	localparam int UMH_IER_MODEM_BIT = 3;
	localparam int UMH_MSR_DELTA_LSB = 0;
	localparam int UMH_MSR_LEVEL_LSB = 4;
	localparam logic [7:0] UMH_MCR_RESET = 8'h00;
	localparam logic [7:0] UMH_IER_RESET = 8'h00;
	localparam logic [15:0] UMH_BASE_STRAP0 = 16'h03F0;
	localparam logic [15:0] UMH_BASE_STRAP1 = 16'h0370;
	localparam logic [31:0] UMH_BAD_READ = 32'h00000000;

	// One port: inputs in order cts, dsr, ri, dcd.
	typedef struct packed {
		logic [7:0] modem_control_reg;
		logic [7:0] ier;
		logic [3:0] delta;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] last;
		logic [3:0] fall;
	} umh_port_t;

	typedef struct packed {
		umh_port_t p1;
		umh_port_t p2;
		logic strap;
		logic strap_done;
		logic [31:0] prdata;
	} umh_state_t;

endpackage

// [dv/umh_modem_model.sv]
// Purpose: Modem side of the handshake pins of both ports.
// Assumes: The bench gives wanted pin levels; they reach the pins one edge later.
// Notes: The strap level shows on the port-2 pin until the block drives it.
`timescale 1ns/1ps
`default_nettype none
module umh_modem_model (
	input wire logic clock,
	input wire logic [3:0] want1,
	input wire logic [3:0] want2,
	input wire logic strap_level,
	input wire logic sr2_out,
	input wire logic sr2_oe,
	output logic sr2_wire,
	output logic [3:0] pins1,
	output logic [3:0] pins2
);
	// The modem moves its lines just after a clock edge.
	always_ff @(posedge clock) begin
		pins1 <= want1;
		pins2 <= want2;
	end
	// The board pull keeps the strap level while the pin is undriven.
	assign sr2_wire = sr2_oe ? sr2_out : strap_level;
endmodule
`default_nettype wire

// [dv/tb.sv]
// Purpose: Self-checking bench for the modem handshake block.
// Assumes: Zero-wait APB slave; modem pins pass three flops.
// Notes: A monitor compares read data with queued notes.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import umh_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, sr1, sr2, sr2_oe, sr2_wire, tr1, tr2, irq1, irq2;
	logic [15:0] base;
	logic [3:0] want1 = 4'h0;
	logic [3:0] want2 = 4'h0;
	logic [3:0] pins1, pins2;
	logic strap = 1'b0;
	logic [3:0] prev1 = 4'hF;
	logic [3:0] prev2 = 4'hF;
	logic [31:0] seed = 32'h906f6efc;
	logic [31:0] rnd;
	logic [31:0] expq [$];
	logic [31:0] mskq [$];
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	umh_modem u_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .send_request_n_port1(sr1),
		.send_request_n_port2(sr2), .send_request_n_port2_in(sr2_wire), .send_request_n_port2_oe(sr2_oe),
		.terminal_ready_n(tr1), .terminal_ready_n_port2(tr2), .clear_to_send_n_port1(pins1[0]),
		.clear_to_send_n_port2(pins2[0]), .set_ready_n_port1(pins1[1]), .set_ready_n_port2(pins2[1]),
		.ring_indicator_n(pins1[2]), .ring_indicator_n_port2(pins2[2]), .carrier_detect_n_port1(pins1[3]),
		.carrier_detect_n_port2(pins2[3]), .irq_port1(irq1), .irq_port2(irq2), .config_base_strap(base));
	umh_modem_model u_modem (.clock(clock), .want1(want1), .want2(want2), .strap_level(strap), .sr2_out(sr2),
		.sr2_oe(sr2_oe), .sr2_wire(sr2_wire), .pins1(pins1), .pins2(pins2));
	// Clock of 20 ns.
	always #10 clock = ~clock;
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) @(posedge clock);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		expq.push_back(e);
		mskq.push_back(m);
		apb(1'b0, a, 32'h00000000);
	endtask
	task automatic do_reset(input logic s);
		@(posedge clock);
		nrst <= 1'b0;
		strap <= s;
		repeat (8) @(posedge clock);
		chk("sr1 reset", 32'h1, sr1);
		chk("tr1 reset", 32'h1, tr1);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		chk("base", s ? UMH_BASE_STRAP1 : UMH_BASE_STRAP0, base);
	endtask
	// Monitor takes the oldest note when read data appears; also the timeout.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			report_and_stop();
		end
		if (psel && penable && pready && !pwrite) begin
			#1;
			chk("prdata", expq.pop_front(), prdata & mskq.pop_front());
		end
	end
	// Main sequence: strap, control outputs, then random modem traffic.
	initial begin
		do_reset(1'b1);
		rd(UMH_CFG_OFF, {16'h0000, UMH_BASE_STRAP1}, 32'hFFFFFFFF);
		do_reset(1'b0);
		rd(UMH_CFG_OFF, {16'h0000, UMH_BASE_STRAP0}, 32'hFFFFFFFF);
		rd(8'h0C, UMH_BAD_READ, 32'hFFFFFFFF);
		for (int m = 0; m < 8; m++) begin
			apb(1'b1, UMH_MCR1_OFF, {27'h0, m[2], 2'h0, m[1:0]});
			apb(1'b1, UMH_MCR2_OFF, {27'h0, m[2], 2'h0, m[1:0]});
			repeat (2) @(posedge clock);
			chk("sr1", {31'h0, ~(m[1] & ~m[2])}, sr1);
			chk("sr2 pin", {31'h0, ~(m[1] & ~m[2])}, sr2_wire);
			chk("tr1", {31'h0, ~(m[0] & ~m[2])}, tr1);
			chk("tr2", {31'h0, ~(m[0] & ~m[2])}, tr2);
		end
		for (int i = 0; i < 16; i++) begin
			rnd = $random(seed);
			apb(1'b1, UMH_IER1_OFF, {28'h0, rnd[4], 3'h0});
			apb(1'b1, UMH_IER2_OFF, {28'h0, rnd[5], 3'h0});
			want1 <= 4'h0;
			want2 <= 4'h0;
			repeat (6) @(posedge clock);
			chk("irq1 fall", {31'h0, rnd[4] & |prev1}, irq1);
			chk("irq2 fall", {31'h0, rnd[5] & |prev2}, irq2);
			rd(UMH_MSR1_OFF, 32'hF0, 32'hFFFFFFF0);
			rd(UMH_MSR2_OFF, 32'hF0, 32'hFFFFFFF0);
			want1 <= rnd[3:0];
			want2 <= rnd[11:8];
			repeat (6) @(posedge clock);
			chk("irq1", rnd[4] & |rnd[3:0], irq1);
			chk("irq2", rnd[5] & |rnd[11:8], irq2);
			rd(UMH_MSR1_OFF, {24'h0, ~rnd[3:0], rnd[3:0]}, 32'hFFFFFFFF);
			rd(UMH_MSR2_OFF, {24'h0, ~rnd[11:8], rnd[11:8]}, 32'hFFFFFFFF);
			rd(UMH_MSR1_OFF, {24'h0, ~rnd[3:0], 4'h0}, 32'hFFFFFFFF);
			rd(UMH_MSR2_OFF, {24'h0, ~rnd[11:8], 4'h0}, 32'hFFFFFFFF);
			repeat (2) @(posedge clock);
			chk("irq1 clear", 32'h0, irq1);
			chk("irq2 clear", 32'h0, irq2);
			prev1 = rnd[3:0];
			prev2 = rnd[11:8];
		end
		repeat (2) @(posedge clock);
		report_and_stop();
	end
endmodule
`default_nettype wire
